// ===== core/acc_pkg.sv
package acc_pkg;

  // ----------------------------------------------------------------
  // Register map (index; byte address is four times the index)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 10;
  localparam logic [7:0] IDX_P4CFG = 8'hAE;
  localparam logic [7:0] IDX_MODE = 8'hB1;
  localparam logic [7:0] IDX_RES_HI = 8'hB2;
  localparam logic [7:0] IDX_RES_LO = 8'hB3;
  localparam logic [7:0] IDX_IRQ = 8'hB4;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int LO_CKS1_BIT = 6;
  localparam int LO_RES_BIT = 5;
  localparam int LO_CKS0_BIT = 4;
  localparam int IRQ_FLAG_BIT = 0;
  localparam int IRQ_EN_BIT = 1;
  localparam logic [7:0] P4CFG_RESET = 8'h00;
  localparam logic [31:0] RDATA_NONE = 32'h0000_0000;

  // Mode register, bit 7 down to bit 0
  typedef struct packed {
    logic enable;
    logic start;
    logic done;
    logic channel_global_enable;
    logic extRef;
    logic [2:0] chSel;
  } acc_mode_t;

  localparam acc_mode_t MODE_RESET = 8'h00;

  // Converter clock select codes
  typedef enum logic [1:0] {
    CKS_DIV16 = 2'b00,
    CKS_DIV8 = 2'b01,
    CKS_DIV1 = 2'b10,
    CKS_DIV2 = 2'b11
  } acc_cks_t;

  // ----------------------------------------------------------------
  // Timing: converter clock periods per conversion
  // ----------------------------------------------------------------
  localparam int DIV_W = 5;
  localparam logic [DIV_W-1:0] RATIO_16 = 5'd16;
  localparam logic [DIV_W-1:0] RATIO_8 = 5'd8;
  localparam logic [DIV_W-1:0] RATIO_2 = 5'd2;
  localparam logic [DIV_W-1:0] RATIO_1 = 5'd1;
  localparam int CONV_PER_PHASE = 4;
  localparam int PHASES_12 = 16;
  localparam int PHASES_8 = 12;
  localparam int TICK_W = 7;
  localparam logic [TICK_W-1:0] TICKS_12 = TICK_W'(PHASES_12 * CONV_PER_PHASE);
  localparam logic [TICK_W-1:0] TICKS_8 = TICK_W'(PHASES_8 * CONV_PER_PHASE);

  // Analog front-end controls, all driven from flops
  typedef struct packed {
    logic converterEnable;
    logic extRefSelect;
    logic [7:0] chanEnable;
    logic [7:0] digIsolate;
  } acc_analog_t;

endpackage

// ===== core/acc_timer.sv
`timescale 1ns/1ps
`default_nettype none
module acc_timer (
  input wire logic sys_clk,
  input wire logic rstSyncN,
  input wire logic run,
  input wire acc_pkg::acc_cks_t clkSel,
  input wire logic res12,
  output logic donePulse
);
  import acc_pkg::*;

  typedef enum logic [1:0] {
    T_IDLE = 2'b00,
    T_RUN = 2'b01,
    T_DONE = 2'b10
  } acc_tstate_t;

  acc_tstate_t state_r;
  logic [DIV_W-1:0] ratio_r;
  logic [DIV_W-1:0] divCnt_r;
  logic [TICK_W-1:0] total_r;
  logic [TICK_W-1:0] tickCnt_r;
  logic wrap;

  // Divided-clock enable: one pulse per converter clock period
  assign wrap = (divCnt_r == ratio_r - DIV_W'(1));

  // Settings latched at start so a mid-conversion write cannot skew it
  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      state_r <= T_IDLE;
      ratio_r <= RATIO_16;
      total_r <= TICKS_8;
      divCnt_r <= '0;
      tickCnt_r <= '0;
      donePulse <= 1'b0;
    end else begin
      donePulse <= 1'b0;
      case (state_r)
        T_IDLE: begin
          divCnt_r <= '0;
          tickCnt_r <= '0;
          if (run) begin
            state_r <= T_RUN;
            total_r <= res12 ? TICKS_12 : TICKS_8;
            case (clkSel)
              CKS_DIV16: ratio_r <= RATIO_16;
              CKS_DIV8: ratio_r <= RATIO_8;
              CKS_DIV1: ratio_r <= RATIO_1;
              CKS_DIV2: ratio_r <= RATIO_2;
              default: ratio_r <= RATIO_16;
            endcase
          end
        end
        T_RUN: begin
          if (!run) begin
            state_r <= T_IDLE; // Aborted by software
          end else if (wrap) begin
            divCnt_r <= '0;
            tickCnt_r <= tickCnt_r + TICK_W'(1);
            if (tickCnt_r == total_r - TICK_W'(1)) begin
              state_r <= T_DONE;
              donePulse <= 1'b1;
            end
          end else begin
            divCnt_r <= divCnt_r + DIV_W'(1);
          end
        end
        T_DONE: state_r <= T_IDLE;
        default: state_r <= T_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

// ===== core/acc_core.sv
// Behaviour
// - Conversion time runs from start bit written one to done flag set.
// - Twelve-bit conversion lasts 64 converter clock periods.
// - Eight-bit conversion lasts 48 converter clock periods.
// - Clock select 00 div16, 01 div8, 10 div1, 11 div2 of CPU clock.
// - Channel select value routes analog input of same index.
// - Only the single selected channel is ever connected.
// - Analog config bit one isolates the pin's digital input path.
// - Start bit clears itself when a conversion finishes.
// - Done flag clears on start written one, sets at end. Here the clear also needs enable written one.
// - End of conversion raises the converter interrupt flag.
// - Software may write done flag to zero after reading result.
// - Result bits 11..4 in high byte, bits 3..0 in low nibble.
// - Resolution bit zero eight-bit, one twelve-bit; eight uses high byte.
// - Mode register layout enable, start, done, channel_global_enable, ref, channel.
// - Clock select bits 6 and 4, resolution bit 5, result read-only.
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module acc_core (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [acc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [11:0] adcSample,
  output acc_pkg::acc_analog_t analogCtrl,
  output logic convIrqFlag,
  output logic convIrqEnable
);
  import acc_pkg::*;

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------

  // Word-aligned match of a bus address to a register index
  function automatic logic regHit(input logic [ADDR_W-1:0] addr,
                                  input logic [7:0] idx);
    regHit = (addr[ADDR_W-1:2] == idx) && (addr[1:0] == 2'b00);
  endfunction

  // One-hot decode of a three-bit channel number
  function automatic logic [7:0] oneHot(input logic [2:0] sel);
    oneHot = 8'h01 << sel;
  endfunction

  // --------------------------------------------------------------
  // Reset release
  // --------------------------------------------------------------
  logic rstMeta_r;
  logic rstSyncN;

  // Asserts at once, releases two edges later to avoid a ragged exit
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rstMeta_r <= 1'b0;
      rstSyncN <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSyncN <= rstMeta_r;
    end
  end

  // --------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------
  acc_mode_t mode_r;
  acc_mode_t wMode;

  // Mode register fields, one flop each
  logic modeEn_r;
  logic modeStart_r;
  logic modeDone_r;
  logic modeGchs_r;
  logic modeRef_r;
  logic [2:0] modeCh_r;

  acc_cks_t cks_r;
  logic res12_r;
  logic [7:0] p4cfg_r;
  logic [7:0] resHigh_r;
  logic [3:0] resLow_r;
  logic [11:0] sampleMeta_r;
  logic [11:0] sampleSync_r;
  logic accessCyc;
  logic commit;
  logic wrEn;
  logic mapped;
  logic donePulse;
  logic completion;
  logic startAccept;
  logic [31:0] rdValue;

  // Register selects and write strobes
  logic hitP4;
  logic hitMode;
  logic hitResHi;
  logic hitResLo;
  logic hitIrq;
  logic wrP4;
  logic wrMode;
  logic wrResLo;
  logic wrIrq;
  logic irqClear;

  // --------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------

  // One wait state: pready rises in the second access cycle
  assign accessCyc = psel && penable;
  assign commit = accessCyc && pready;
  assign wrEn = commit && pwrite;
  assign wMode = acc_mode_t'(pwdata[7:0]);

  // --------------------------------------------------------------
  // Register decode
  // --------------------------------------------------------------

  // Selects for the write strobes, hitResHi feeding none; the read mux and the map check decode the address again
  assign hitP4 = regHit(paddr, IDX_P4CFG);
  assign hitMode = regHit(paddr, IDX_MODE);
  assign hitResHi = regHit(paddr, IDX_RES_HI);
  assign hitResLo = regHit(paddr, IDX_RES_LO);
  assign hitIrq = regHit(paddr, IDX_IRQ);

  // Write strobes; each fires only on the edge that ends a transfer
  assign wrP4 = wrEn && hitP4;
  assign wrMode = wrEn && hitMode;
  assign wrResLo = wrEn && hitResLo;
  assign wrIrq = wrEn && hitIrq;
  // A one in the flag position is ignored, so software can only clear
  // the request and never fake a finished conversion
  assign irqClear = wrIrq && !pwdata[IRQ_FLAG_BIT];

  // Any other word answers with an error and has no side effect
  assign mapped = regHit(paddr, IDX_P4CFG) || regHit(paddr, IDX_MODE) ||
                  regHit(paddr, IDX_RES_HI) || regHit(paddr, IDX_RES_LO) ||
                  regHit(paddr, IDX_IRQ);

  // Read mux; the analog config register is write-only and reads zero
  always_comb begin
    rdValue = RDATA_NONE;
    if (regHit(paddr, IDX_MODE)) begin
      rdValue[7:0] = mode_r;
    end else if (regHit(paddr, IDX_RES_HI)) begin
      rdValue[7:0] = resHigh_r;
    end else if (regHit(paddr, IDX_RES_LO)) begin
      rdValue[LO_CKS1_BIT] = cks_r[1];
      rdValue[LO_RES_BIT] = res12_r;
      rdValue[LO_CKS0_BIT] = cks_r[0];
      rdValue[3:0] = resLow_r;
    end else if (regHit(paddr, IDX_IRQ)) begin
      rdValue[IRQ_FLAG_BIT] = convIrqFlag;
      rdValue[IRQ_EN_BIT] = convIrqEnable;
    end
  end

  // Answer flops; read data frozen for the cycle pready is high
  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= RDATA_NONE;
    end else begin
      pready <= accessCyc && !pready;
      pslverr <= accessCyc && !pready && !mapped;
      if (accessCyc && !pready) begin
        prdata <= pwrite ? RDATA_NONE : rdValue;
      end
    end
  end

  // --------------------------------------------------------------
  // Conversion control
  // --------------------------------------------------------------

  // A start write only counts with the converter enabled
  assign startAccept = wrMode && wMode.start && wMode.enable;
  // Finish only counts while the start bit still stands
  assign completion = donePulse && mode_r.start;

  // Timer follows the start bit and idles one edge after start drops; an aborted conversion can
  // still raise donePulse on the abort edge, which the start gate on completion then ignores
  acc_timer u_timer (
    .sys_clk(sys_clk),
    .rstSyncN(rstSyncN),
    .run(mode_r.start),
    .clkSel(cks_r),
    .res12(res12_r),
    .donePulse(donePulse)
  );

  // --------------------------------------------------------------
  // Mode register
  // --------------------------------------------------------------

  // Software view; each field has its own flop and a single writer
  assign mode_r = {modeEn_r, modeStart_r, modeDone_r, modeGchs_r, modeRef_r,
                   modeCh_r};

  // Configuration fields take effect at once; software must not move
  // the channel while a conversion is sampling it
  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      modeEn_r <= MODE_RESET.enable;
      modeGchs_r <= MODE_RESET.channel_global_enable;
      modeRef_r <= MODE_RESET.extRef;
      modeCh_r <= MODE_RESET.chSel;
    end else if (wrMode) begin
      modeEn_r <= wMode.enable;
      modeGchs_r <= wMode.channel_global_enable;
      modeRef_r <= wMode.extRef;
      modeCh_r <= wMode.chSel;
    end
  end

  // Start bit; writing zero or disabling the converter aborts
  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      modeStart_r <= MODE_RESET.start;
    end else if (wrMode) begin
      modeStart_r <= wMode.start && wMode.enable;
    end else if (completion) begin
      modeStart_r <= 1'b0;
    end
  end

  // Done flag; a finishing conversion beats a software clear
  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      modeDone_r <= MODE_RESET.done;
    end else if (startAccept) begin
      modeDone_r <= 1'b0;
    end else if (completion) begin
      modeDone_r <= 1'b1;
    end else if (wrMode && !wMode.done) begin
      modeDone_r <= 1'b0;
    end
  end

  // Clock select and resolution; set these before starting
  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      cks_r <= CKS_DIV16;
      res12_r <= 1'b0;
    end else if (wrResLo) begin
      cks_r <= acc_cks_t'({pwdata[LO_CKS1_BIT], pwdata[LO_CKS0_BIT]});
      res12_r <= pwdata[LO_RES_BIT];
    end
  end

  // Port-four analog configuration, write-only
  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      p4cfg_r <= P4CFG_RESET;
    end else if (wrP4) begin
      p4cfg_r <= pwdata[7:0];
    end
  end

  // --------------------------------------------------------------
  // Result capture
  // --------------------------------------------------------------

  // The analog core holds its code steady near the end of a
  // conversion, so a plain two-flop bus sync is adequate here
  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      sampleMeta_r <= '0;
      sampleSync_r <= '0;
    end else begin
      sampleMeta_r <= adcSample;
      sampleSync_r <= sampleMeta_r;
    end
  end

  // Result lands on the same edge as the done and interrupt flags
  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      resHigh_r <= '0;
      resLow_r <= '0;
    end else if (completion) begin
      resHigh_r <= sampleSync_r[11:4];
      resLow_r <= res12_r ? sampleSync_r[3:0] : 4'h0;
    end
  end

  // --------------------------------------------------------------
  // Interrupt request flag and enable
  // --------------------------------------------------------------

  // Flag set by the finish wins over a clear written the same cycle
  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      convIrqFlag <= 1'b0;
    end else if (completion) begin
      convIrqFlag <= 1'b1;
    end else if (irqClear) begin
      convIrqFlag <= 1'b0;
    end
  end

  // Enable is only stored and driven out beside the flag; it never gates the flag
  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      convIrqEnable <= 1'b0;
    end else if (wrIrq) begin
      convIrqEnable <= pwdata[IRQ_EN_BIT];
    end
  end

  // --------------------------------------------------------------
  // Analog front-end controls
  // --------------------------------------------------------------

  // Registered so switch controls never glitch during decode
  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      analogCtrl <= '0;
    end else begin
      analogCtrl.converterEnable <= mode_r.enable;
      analogCtrl.extRefSelect <= mode_r.extRef;
      analogCtrl.chanEnable <= mode_r.channel_global_enable ?
                               oneHot(mode_r.chSel) : 8'h00;
      analogCtrl.digIsolate <= p4cfg_r;
    end
  end

endmodule
`default_nettype wire

// ===== dv/acc_core_chk.sv
`timescale 1ns/1ps
`default_nettype none
module acc_core_chk (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [acc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [11:0] adcSample,
  input wire acc_pkg::acc_analog_t analogCtrl,
  input wire logic convIrqFlag,
  input wire logic convIrqEnable
);
  import acc_pkg::*;
  // ----------------
  // Register shadows
  // ----------------
  logic commit, irqClr;
  logic [7:0] idx, isoSh_r, expChan;
  logic [2:0] loSh_r;
  logic [1:0] expCtl;
  logic [10:0] cnt_r, expN_r, ratio, expN;
  acc_mode_t modeSh_r;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // Writes count only at the edge where the slave answers
  assign commit = psel && penable && pready && pwrite;
  assign idx = paddr[9:2];
  assign irqClr = commit && idx == IDX_IRQ && !pwdata[IRQ_FLAG_BIT];
  assign ratio = loSh_r[2] ? (loSh_r[0] ? 11'd2 : 11'd1)
                           : (loSh_r[0] ? 11'd8 : 11'd16);
  assign expN = ratio * (loSh_r[1] ? 11'd64 : 11'd48) + 11'd2;
  assign expChan = modeSh_r.channel_global_enable ? 8'h01 << modeSh_r.chSel : 8'h00;
  assign expCtl = {modeSh_r.enable, modeSh_r.extRef};
  // Shadows of the writable fields
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      modeSh_r <= MODE_RESET;
      isoSh_r <= 8'h00;
      loSh_r <= 3'h0;
    end else if (commit) begin
      if (idx == IDX_MODE) modeSh_r <= pwdata[7:0];
      if (idx == IDX_P4CFG) isoSh_r <= pwdata[7:0];
      if (idx == IDX_RES_LO) loSh_r <= pwdata[6:4];
    end
  end
  // Cycles since an accepted start; saturates so a stray flag fails
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= '1;
      expN_r <= '0;
    end else if (commit && idx == IDX_MODE && pwdata[7:6] == 2'b11) begin
      cnt_r <= '0;
      expN_r <= expN;
    end else if (cnt_r != '1) begin
      cnt_r <= cnt_r + 11'd1;
    end
  end
  rdy_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("no ready in second access cycle");
  err_ack_a: assert property (pslverr |-> pready && prdata == RDATA_NONE)
    else $error("bad error response");
  chan_single_a: assert property ($onehot0(analogCtrl.chanEnable))
    else $error("more than one channel connected");
  chan_route_a: assert property (1'b1 |=>
    analogCtrl.chanEnable == $past(expChan))
    else $error("wrong channel connected");
  iso_mirror_a: assert property (1'b1 |=>
    analogCtrl.digIsolate == $past(isoSh_r))
    else $error("isolation differs from config");
  ctl_mirror_a: assert property (1'b1 |=>
    {analogCtrl.converterEnable, analogCtrl.extRefSelect} == $past(expCtl))
    else $error("enable or reference select differs");
  irq_time_a: assert property ($rose(convIrqFlag) |-> cnt_r == expN_r)
    else $error("conversion length wrong");
  irq_hold_a: assert property ($fell(convIrqFlag) |-> $past(irqClr))
    else $error("irq flag dropped without clear");
endmodule
bind acc_core acc_core_chk u_chk (.sys_clk, .rstn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .adcSample,
  .analogCtrl, .convIrqFlag, .convIrqEnable);
`default_nettype wire

// ===== dv/acc_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module acc_src_model (
  input wire logic sys_clk,
  input wire logic [7:0] chanEnable,
  output logic [11:0] adcSample
);
  // ----------------
  // Pin sources
  // ----------------
  logic [11:0] idleCode = 12'h000;
  // Floating input: new pattern each cycle, never a stale level
  always @(posedge sys_clk) idleCode <= idleCode + 12'h3A7;
  // Each pin holds its own level; only a connected pin reaches the core
  always_comb begin
    adcSample = idleCode;
    for (int i = 0; i < 8; i++) begin
      if (chanEnable[i]) adcSample = 12'hA5C ^ {i[2:0], 9'h000};
    end
  end
endmodule
`default_nettype wire

// ===== dv/acc_core_test.sv
`timescale 1ns/1ps
`default_nettype none
module acc_core_test;
  import acc_pkg::*;
  localparam int WARMUP = 12500;
  logic sys_clk, rstn, psel, penable, pwrite, pready, pslverr, lastErr;
  logic convIrqFlag, convIrqEnable, res;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [11:0] adcSample, code;
  logic [1:0] cks;
  acc_analog_t analogCtrl;
  longint tS;
  int n;
  int nErrors = 0;
  int checks = 0;
  int ratioTbl[4] = '{16, 8, 1, 2};
  acc_core DUT (.sys_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .adcSample, .analogCtrl, .convIrqFlag,
    .convIrqEnable);
  acc_src_model src (.sys_clk, .chanEnable(analogCtrl.chanEnable),
    .adcSample);
  // ----------------
  // Bus tasks
  // ----------------
  // Request held until ready is seen at an edge
  task automatic apb(input logic isWr, input logic [7:0] idx,
                     input logic [7:0] wd);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= isWr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      nErrors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd, {24'h0, exp});
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge sys_clk);
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checks, nErrors);
    if (nErrors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ----------------
  // Clock, watchdog, tests
  // ----------------
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Tests need about 16300 cycles
  initial begin
    cyc(40000);
    nErrors++;
    final_report();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    rstn = 1'b0;
    cyc(12);
    rstn <= 1'b1;
    cyc(3);
    rdc(IDX_MODE, 8'h00);
    rdc(IDX_RES_LO, 8'h00);
    rdc(IDX_P4CFG, 8'h00);
    apb(1'b0, 8'h40, 8'h00);
    chk(32'(lastErr), 32'h1);
    wr(IDX_RES_HI, 8'hFF);
    rdc(IDX_RES_HI, 8'h00);
    wr(IDX_RES_LO, 8'h7F);
    rdc(IDX_RES_LO, 8'h70);
    wr(IDX_IRQ, 8'h01);
    rdc(IDX_IRQ, 8'h00);
    $display("test registers done");
    wr(IDX_P4CFG, 8'hA5);
    for (int ch = 0; ch < 8; ch++) begin
      wr(IDX_MODE, 8'(ch));
      wr(IDX_MODE, 8'h10 | 8'(ch));
      cyc(2);
      chk(32'(analogCtrl), {16'h0, 8'h01 << ch, 8'hA5});
    end
    wr(IDX_MODE, 8'h08);
    cyc(2);
    chk(32'(analogCtrl), 32'h0001_00A5);
    $display("test channels done");
    wr(IDX_MODE, 8'h80);
    cyc(WARMUP);
    for (int i = 0; i < 8; i++) begin
      cks = i[1:0];
      res = i[2];
      code = 12'hA5C ^ {i[2:0], 9'h000};
      wr(IDX_RES_LO, {1'b0, cks[1], res, cks[0], 4'h0});
      wr(IDX_MODE, 8'h80 | 8'(i));
      wr(IDX_MODE, 8'h90 | 8'(i));
      wr(IDX_IRQ, 8'h02);
      wr(IDX_MODE, 8'hD0 | 8'(i));
      tS = $time;
      rdc(IDX_MODE, 8'hD0 | 8'(i));
      n = 0;
      while (convIrqFlag !== 1'b1 && n < 2000) begin
        @(posedge sys_clk);
        n++;
      end
      chk(32'(($time - tS) / 8), 32'(ratioTbl[cks] * (res ? 64 : 48) + 3));
      rdc(IDX_MODE, 8'hB0 | 8'(i));
      rdc(IDX_RES_HI, code[11:4]);
      rdc(IDX_RES_LO, {1'b0, cks[1], res, cks[0], res ? code[3:0] : 4'h0});
      rdc(IDX_IRQ, 8'h03);
      wr(IDX_MODE, 8'h90 | 8'(i));
      rdc(IDX_MODE, 8'h90 | 8'(i));
    end
    chk(32'({convIrqFlag, convIrqEnable}), 32'h3);
    wr(IDX_IRQ, 8'h00);
    cyc(1);
    chk(32'({convIrqFlag, convIrqEnable}), 32'h0);
    $display("test conversions done");
    wr(IDX_MODE, 8'h50);
    cyc(200);
    rdc(IDX_MODE, 8'h10);
    chk(32'(convIrqFlag), 32'h0);
    $display("test disabled start done");
    final_report();
  end
endmodule
`default_nettype wire
